// file: src/rxo_fifo.sv
/*
 small flip-flop fifo with valid/ready on both sides.
 assumes one clock and asynchronous active low reset.
*/
`timescale 1ns/100ps
module rxo_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    logic [AW:0] next_count;
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
        end
    end

    chk_fifo_no_overflow: assert property (@(posedge clk_sys) disable iff (!reset_n)
        count <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule : rxo_fifo

// file: src/rxo_params.svh
/*
 constants for the expansion port output control block.
 assumes inclusion by bare name from src/.
*/
`ifndef RXO_PARAMS_SVH
`define RXO_PARAMS_SVH

// ----------------------------------------
// register offsets and reset values
// ----------------------------------------
`define RXO_OFS_XPORT_CTRL 8'h13
`define RXO_OFS_COMPAT_CTRL 8'h14
`define RXO_RST_XPORT_CTRL 8'h00
`define RXO_RST_COMPAT_CTRL 8'h00

// ----------------------------------------
// field positions, port control register
// ----------------------------------------
`define RXO_BIT_RT_OE 7
`define RXO_BIT_HOR_SEL 6
`define RXO_POS_VERT_SEL 4
`define RXO_BIT_LOCK_SEL 3
`define RXO_POS_FMT 0

// ----------------------------------------
// field positions, compatibility register
// ----------------------------------------
`define RXO_BIT_COMPAT 7
`define RXO_BIT_GAIN 6
`define RXO_POS_TEST 4
`define RXO_BIT_XTOE 3
`define RXO_BIT_AUTO 2
`define RXO_POS_PHASE 0

// ----------------------------------------
// timing
// ----------------------------------------
`define RXO_CLK_MHZ 100
`define RXO_LLC_MHZ 27
`define RXO_HALF_MHZ 13.5
`define RXO_EIGHTH_DIV 4
`define RXO_FIFO_DEPTH 8

`endif

// file: src/rxo_pkg.sv
/*
 types for the expansion port output control block.
 assumes rxo_params.svh defines the numbers.
*/
package rxo_pkg;

    typedef enum logic [2:0] {
        RXO_FMT_656 = 3'h0,
        RXO_FMT_656_VG = 3'h1,
        RXO_FMT_422 = 3'h2,
        RXO_FMT_RSV3 = 3'h3,
        RXO_FMT_BYP_HI = 3'h4,
        RXO_FMT_BYP_LO = 3'h5,
        RXO_FMT_RSV6 = 3'h6,
        RXO_FMT_MSB_LSB = 3'h7
    } rxo_fmt_e;

    typedef struct packed {
        logic rt_ctrl_out_enable;
        logic xport_hor_ref_select;
        logic [1:0] xport_vert_ref_select;
        logic lock_indicator_select;
        rxo_fmt_e port_output_format;
    } rxo_xctrl_s;

    typedef struct packed {
        logic reencoder_compat_bit;
        logic gain_update_interval;
        logic [1:0] test_sel_low;
        logic crystal_out_enable;
        logic auto_chroma_detect_ctrl;
        logic [1:0] converter_sample_phase;
    } rxo_compat_s;

    typedef struct packed {
        logic [8:0] conv_a;
        logic [8:0] conv_b;
        logic two_conv;
    } rxo_conv_s;

    typedef enum logic [1:0] {
        RXO_HS_IDLE = 2'h0,
        RXO_HS_WAIT = 2'h1,
        RXO_HS_PULSE = 2'h3
    } rxo_hs_e;

endpackage : rxo_pkg

// file: src/rxo_xport_ctrl.sv
/*
 expansion port output control: reference pin routing, lock indicator,
 byte format mux feeding an output fifo, control pin enables.
 assumes all timing inputs already run on clk_sys; register writes
 arrive as a strobe with offset and byte.
*/
// What this block does
// - hor ref pin: active line or hsync
// - hsync width eighth-rate, half-rate fine delay
// - vert ref pin: vsync, field id, inverted
// - lock out: inverted status or fast
// - format 000 656, 001 gated blanking
// - format 010 plain 422; 011,110 reserved
// - format 100 bypass bits 8..1 interleaved
// - format 101 bypass bits 7..0 interleaved
// - format 111 lower then upper bits
// - gain update per line or field
// - test mux: ground, converters, bandpass point
// - half-rate reference toggles every clk_sys cycle except on line_start, which clears it
// - alt gate position: field two one line earlier
`timescale 1ns/100ps
`include "rxo_params.svh"
module rxo_xport_ctrl #(
    parameter int FIFO_DEPTH = `RXO_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // register access
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic test_sel_high,
    // timing references from the decoder core
    input wire logic active_line_ref,
    input wire logic line_start,
    input wire logic field_start,
    input wire logic vertical_sync_pulse,
    input wire logic field_id,
    input wire logic [8:0] line_number,
    input wire logic [7:0] hsync_begin_field,
    input wire logic [7:0] hsync_stop_field,
    input wire logic [1:0] hsync_fine_delay,
    input wire logic [8:0] vertical_gate_start_line,
    input wire logic [8:0] vertical_gate_stop_line,
    input wire logic vertical_gate_alt_position,
    input wire logic horizontal_lock_status,
    input wire logic fast_lock,
    // video and converter data
    input wire logic [7:0] video_byte,
    input wire logic video_is_code,
    input wire logic video_valid,
    input wire rxo_pkg::rxo_conv_s conv,
    input wire logic conv_valid,
    input wire logic rt_ctrl_data,
    input wire logic crystal_clk,
    // expansion port
    output logic xport_hor_ref_pin,
    output logic xport_vert_ref_pin,
    output logic horizontal_lock_output,
    output logic half_rate_reference,
    output logic [7:0] xport_data_bus,
    output logic xport_data_valid,
    input wire logic xport_data_ready,
    output logic data_source_ready,
    // control pins and misc outputs
    output logic realtime_control_output,
    output logic realtime_control_output_oe,
    output logic crystal_clock_output,
    output logic crystal_clock_output_oe,
    output logic gain_update,
    output logic [2:0] analog_test_select,
    output logic [1:0] converter_sample_phase,
    output logic reencoder_compat_bit
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    rxo_pkg::rxo_xctrl_s xctrl;
    rxo_pkg::rxo_compat_s compat;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            xctrl <= `RXO_RST_XPORT_CTRL;
            compat <= `RXO_RST_COMPAT_CTRL;
        end else if (reg_write) begin
            if (reg_addr == `RXO_OFS_XPORT_CTRL) begin
                xctrl <= reg_wdata;
            end
            if (reg_addr == `RXO_OFS_COMPAT_CTRL) begin
                compat <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_addr == `RXO_OFS_XPORT_CTRL) begin
            reg_rdata <= xctrl;
        end else if (reg_addr == `RXO_OFS_COMPAT_CTRL) begin
            reg_rdata <= compat;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------
    // half-rate reference and eighth-rate ticks
    // ----------------------------------------
    logic [1:0] eighth_cnt;
    logic eighth_tick;
    assign eighth_tick = half_rate_reference && (eighth_cnt == 2'h3);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            half_rate_reference <= 1'b0;
            eighth_cnt <= 2'h0;
        end else if (line_start) begin
            half_rate_reference <= 1'b0;
            eighth_cnt <= 2'h0;
        end else begin
            half_rate_reference <= !half_rate_reference;
            if (half_rate_reference) begin
                eighth_cnt <= eighth_cnt + 2'h1;
            end
        end
    end

    // ----------------------------------------
    // programmable hsync
    // ----------------------------------------
    rxo_pkg::rxo_hs_e hs_state;
    logic [7:0] hs_count;
    logic [1:0] hs_fine;
    logic hs_raw;
    logic [3:0] hs_delay_line;
    logic programmable_hsync;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hs_state <= rxo_pkg::RXO_HS_IDLE;
            hs_count <= 8'h00;
            hs_raw <= 1'b0;
        end else if (line_start) begin
            hs_state <= rxo_pkg::RXO_HS_WAIT;
            hs_count <= 8'h00;
            hs_raw <= 1'b0;
        end else if (eighth_tick) begin
            hs_count <= hs_count + 8'h01;
            unique case (hs_state)
                rxo_pkg::RXO_HS_IDLE: begin
                    hs_raw <= 1'b0;
                end
                rxo_pkg::RXO_HS_WAIT: begin
                    if (hs_count == hsync_begin_field) begin
                        hs_state <= rxo_pkg::RXO_HS_PULSE;
                        hs_raw <= 1'b1;
                    end
                end
                rxo_pkg::RXO_HS_PULSE: begin
                    if (hs_count == hsync_stop_field) begin
                        hs_state <= rxo_pkg::RXO_HS_IDLE;
                        hs_raw <= 1'b0;
                    end
                end
                default: begin
                    hs_state <= rxo_pkg::RXO_HS_IDLE;
                end
            endcase
        end
    end

    // fine delay in half-rate steps
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hs_delay_line <= 4'h0;
            hs_fine <= 2'h0;
        end else begin
            hs_fine <= hsync_fine_delay;
            if (half_rate_reference) begin
                hs_delay_line <= {hs_delay_line[2:0], hs_raw};
            end
        end
    end

    assign programmable_hsync = (hs_fine == 2'h0) ? hs_raw : hs_delay_line[hs_fine - 2'h1];

    // ----------------------------------------
    // vertical gate
    // ----------------------------------------
    logic vertical_gate;
    logic [8:0] gate_start;
    logic [8:0] gate_stop;
    always_comb begin
        gate_start = vertical_gate_start_line;
        gate_stop = vertical_gate_stop_line;
        if (vertical_gate_alt_position && field_id) begin
            gate_start = vertical_gate_start_line - 9'h001;
            gate_stop = vertical_gate_stop_line - 9'h001;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            vertical_gate <= 1'b0;
        end else if (line_start) begin
            if (line_number == gate_start) begin
                vertical_gate <= 1'b1;
            end else if (line_number == gate_stop) begin
                vertical_gate <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // reference pins and lock output
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            xport_hor_ref_pin <= 1'b0;
            xport_vert_ref_pin <= 1'b0;
            horizontal_lock_output <= 1'b0;
        end else begin
            xport_hor_ref_pin <= xctrl.xport_hor_ref_select ? programmable_hsync
                                                           : active_line_ref;
            unique case (xctrl.xport_vert_ref_select)
                2'h0: xport_vert_ref_pin <= vertical_sync_pulse;
                2'h1: xport_vert_ref_pin <= field_id;
                2'h2: xport_vert_ref_pin <= !vertical_sync_pulse;
                2'h3: xport_vert_ref_pin <= !field_id;
            endcase
            horizontal_lock_output <= xctrl.lock_indicator_select ? fast_lock
                                                                 : !horizontal_lock_status;
        end
    end

    // ----------------------------------------
    // output byte format
    // ----------------------------------------
    logic [7:0] fmt_byte;
    logic fmt_valid;
    always_comb begin
        fmt_byte = 8'h00;
        fmt_valid = 1'b0;
        unique case (xctrl.port_output_format)
            rxo_pkg::RXO_FMT_656: begin
                fmt_byte = video_byte;
                fmt_valid = video_valid;
            end
            rxo_pkg::RXO_FMT_656_VG: begin
                fmt_byte = (vertical_gate || video_is_code) ? video_byte : 8'h80;
                fmt_valid = video_valid;
            end
            rxo_pkg::RXO_FMT_422: begin
                fmt_byte = video_byte;
                fmt_valid = video_valid && !video_is_code;
            end
            rxo_pkg::RXO_FMT_BYP_HI: begin
                fmt_byte = (conv.two_conv && half_rate_reference) ? conv.conv_b[8:1]
                                                                  : conv.conv_a[8:1];
                fmt_valid = conv_valid;
            end
            rxo_pkg::RXO_FMT_BYP_LO: begin
                fmt_byte = (conv.two_conv && half_rate_reference) ? conv.conv_b[7:0]
                                                                  : conv.conv_a[7:0];
                fmt_valid = conv_valid;
            end
            rxo_pkg::RXO_FMT_MSB_LSB: begin
                fmt_byte = half_rate_reference ? conv.conv_a[8:1] : conv.conv_a[7:0];
                fmt_valid = conv_valid;
            end
            rxo_pkg::RXO_FMT_RSV3, rxo_pkg::RXO_FMT_RSV6: begin
                fmt_valid = 1'b0;
            end
        endcase
    end

    logic [7:0] fifo_byte;
    logic fifo_valid;
    rxo_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .in_valid(fmt_valid),
        .in_ready(data_source_ready),
        .in_data(fmt_byte),
        .out_valid(fifo_valid),
        .out_ready(!xport_data_valid || xport_data_ready),
        .out_data(fifo_byte)
    );

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            xport_data_bus <= 8'h00;
            xport_data_valid <= 1'b0;
        end else if (!xport_data_valid || xport_data_ready) begin
            xport_data_bus <= fifo_byte;
            xport_data_valid <= fifo_valid;
        end
    end

    // ----------------------------------------
    // control pins, gain update, misc fields
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            realtime_control_output <= 1'b0;
            realtime_control_output_oe <= 1'b0;
            crystal_clock_output <= 1'b0;
            crystal_clock_output_oe <= 1'b0;
            gain_update <= 1'b0;
            analog_test_select <= 3'h0;
            converter_sample_phase <= 2'h0;
            reencoder_compat_bit <= 1'b0;
        end else begin
            realtime_control_output <= rt_ctrl_data;
            realtime_control_output_oe <= xctrl.rt_ctrl_out_enable;
            crystal_clock_output <= crystal_clk;
            crystal_clock_output_oe <= compat.crystal_out_enable;
            gain_update <= compat.gain_update_interval ? field_start : line_start;
            // reserved codes pass through; the analog mux grounds them
            analog_test_select <= {test_sel_high, compat.test_sel_low};
            converter_sample_phase <= compat.converter_sample_phase;
            reencoder_compat_bit <= compat.reencoder_compat_bit;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_hor_ref_sel: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reset_n && !xctrl.xport_hor_ref_select |=> xport_hor_ref_pin == $past(active_line_ref))
        else $error("hor ref pin not active line");
    chk_vert_ref_inv: assert property (@(posedge clk_sys) disable iff (!reset_n)
        xctrl.xport_vert_ref_select == 2'h2 |=> xport_vert_ref_pin == !$past(vertical_sync_pulse))
        else $error("vert ref pin not inverted vsync");
    chk_lock_out_inv: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reset_n && !xctrl.lock_indicator_select
        |=> horizontal_lock_output == !$past(horizontal_lock_status))
        else $error("lock output not inverted status");
    chk_half_rate_tog: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reset_n && !line_start |=> half_rate_reference != $past(half_rate_reference))
        else $error("half rate reference did not toggle");
    chk_reserved_fmt: assert property (@(posedge clk_sys) disable iff (!reset_n)
        xctrl.port_output_format == rxo_pkg::RXO_FMT_RSV3 |-> !fmt_valid)
        else $error("reserved format produced data");
    chk_byp_interleave: assert property (@(posedge clk_sys) disable iff (!reset_n)
        xctrl.port_output_format == rxo_pkg::RXO_FMT_BYP_HI && conv.two_conv
        && half_rate_reference |-> fmt_byte == conv.conv_b[8:1])
        else $error("bypass byte from wrong converter");
    chk_msb_lsb_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
        xctrl.port_output_format == rxo_pkg::RXO_FMT_MSB_LSB && !half_rate_reference
        |-> fmt_byte == conv.conv_a[7:0])
        else $error("low half byte wrong");
    chk_rt_oe_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !xctrl.rt_ctrl_out_enable ##1 !$past(xctrl.rt_ctrl_out_enable) |-> !realtime_control_output_oe)
        else $error("control pin driven while disabled");
    chk_gain_field: assert property (@(posedge clk_sys) disable iff (!reset_n)
        compat.gain_update_interval && !field_start |=> !gain_update)
        else $error("gain update outside field start");
endmodule : rxo_xport_ctrl

// file: test/rxo_sink.sv
/*
 receiver model on the far side of the port: takes bytes on valid/ready.
 assumes one clock and asynchronous active low reset.
*/
`timescale 1ns/100ps
module rxo_sink (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // stall mode: 0 prompt, 1 slow, 2 stopped
    input wire logic [1:0] mode,
    // port side
    input wire logic [7:0] xport_data_bus,
    input wire logic xport_data_valid,
    output logic xport_data_ready,
    // bytes taken
    output logic got,
    output logic [7:0] got_byte
);
    logic [7:0] lfsr;

    // ----------------------------------------
    // ready pattern and capture
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lfsr <= 8'hA5;
            xport_data_ready <= 1'b0;
            got <= 1'b0;
            got_byte <= 8'h00;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            xport_data_ready <= (mode == 2'h0) | ((mode == 2'h1) & lfsr[0]);
            got <= xport_data_valid & xport_data_ready;
            got_byte <= xport_data_bus;
        end
    end
endmodule : rxo_sink

// file: test/rxo_xport_ctrl_tb.sv
/*
 self-checking bench for the port output control block.
 assumes rxo_sink and the design sources are compiled first.
*/
`timescale 1ns/100ps
module rxo_xport_ctrl_tb;
    logic clk_sys = 1'b0;
    logic reset_n, reg_write, test_sel_high, active_line_ref, line_start, field_start;
    logic vertical_sync_pulse, field_id, vertical_gate_alt_position, horizontal_lock_status;
    logic fast_lock, video_is_code, video_valid, conv_valid, rt_ctrl_data, crystal_clk;
    logic xport_hor_ref_pin, xport_vert_ref_pin, horizontal_lock_output, half_rate_reference;
    logic xport_data_valid, xport_data_ready, data_source_ready, realtime_control_output;
    logic realtime_control_output_oe, crystal_clock_output, crystal_clock_output_oe;
    logic gain_update, reencoder_compat_bit, got, ok, ex, v;
    logic [1:0] hsync_fine_delay, converter_sample_phase, mode;
    logic [2:0] analog_test_select;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, hsync_begin_field, hsync_stop_field;
    logic [7:0] video_byte, xport_data_bus, got_byte, x, w, b, ev, eh;
    logic [8:0] line_number, vertical_gate_start_line, vertical_gate_stop_line, c;
    rxo_pkg::rxo_conv_s conv;
    logic [7:0] q[$];
    int seed = 32'hc21088f4;
    int miscompares = 0, compares = 0, cyc = 0, i, n, f;

    rxo_xport_ctrl DUT (.*);
    rxo_sink SINK (.*);

    always #5 clk_sys = ~clk_sys;

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task cmp8(input string nm, input logic [7:0] exv, input logic [7:0] sn);
        compares++;
        if (exv !== sn) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exv, sn);
        end
    endtask : cmp8

    task complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        @(posedge clk_sys);
        @(negedge clk_sys);
        cmp8("reg_rdata", e, reg_rdata);
    endtask : rd

    task settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle

    task pulse(input logic fld, input logic [7:0] exn);
        @(posedge clk_sys);
        line_start <= !fld;
        field_start <= fld;
        @(posedge clk_sys);
        {line_start, field_start} <= 2'h0;
        n = 0;
        repeat (6) begin
            @(negedge clk_sys);
            n += gain_update;
        end
        cmp8("gain_update count", exn, 8'(n));
    endtask : pulse

    task push(input logic cs, input logic [7:0] bb, input logic [8:0] cc, input logic code);
        @(posedge clk_sys);
        video_valid <= !cs;
        conv_valid <= cs;
        video_byte <= bb;
        video_is_code <= code;
        conv <= '{cc, ~cc, 1'($random(seed)) & (f != 7)};
        @(negedge clk_sys);
        ok = data_source_ready;
        if (ok && ex) q.push_back((cs && half_rate_reference && (conv.two_conv || f == 7)) ? eh : ev);
    endtask : push

    task flush;
        @(posedge clk_sys);
        {video_valid, conv_valid} <= 2'h0;
        mode <= 2'h0;
        for (n = 0; n < 300 && q.size() != 0; n++) @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
        cmp8("pending bytes", 8'h00, 8'(q.size()));
    endtask : flush

    // ----------------------------------------
    // output watcher and hang limit
    // ----------------------------------------
    always @(negedge clk_sys) begin
        if (got === 1'b1) begin
            if (q.size() == 0) begin
                miscompares++;
                $display("ERROR xport_data_bus expected none seen %h", got_byte);
            end else cmp8("xport_data_bus", q.pop_front(), got_byte);
        end
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            complete_run;
        end
    end

    initial begin
        {reg_write, test_sel_high, active_line_ref, line_start, field_start, field_id} = '0;
        {vertical_sync_pulse, vertical_gate_alt_position, horizontal_lock_status, fast_lock} = '0;
        {video_is_code, video_valid, conv_valid, rt_ctrl_data, crystal_clk, reset_n} = '0;
        {reg_addr, reg_wdata, hsync_begin_field, hsync_stop_field, video_byte} = '0;
        {hsync_fine_delay, conv, mode} = '0;
        line_number = 9'h064;
        vertical_gate_start_line = 9'h00A;
        vertical_gate_stop_line = 9'h014;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(8'h13, 8'h00);
        rd(8'h14, 8'h00);
        cmp8("rtc_oe", 8'h00, 8'(realtime_control_output_oe));
        wr(8'h15, 8'hFF);
        rd(8'h15, 8'h00);
        for (i = 0; i < 8; i++) begin
            w = 8'($random(seed));
            w[7] = 1'b0;
            @(posedge clk_sys);
            test_sel_high <= i[1];
            wr(8'h14, w);
            settle;
            cmp8("analog_test_select", 8'({i[1], w[5:4]}), 8'(analog_test_select));
            cmp8("xtal_oe", 8'(w[3]), 8'(crystal_clock_output_oe));
            cmp8("sample_phase", 8'(w[1:0]), 8'(converter_sample_phase));
            cmp8("compat_bit", 8'h00, 8'(reencoder_compat_bit));
            rd(8'h14, w);
            pulse(1'b0, 8'(!w[6]));
            pulse(1'b1, 8'(w[6]));
        end
        for (i = 0; i < 16; i++) begin
            x = 8'($random(seed));
            x[2:0] = 3'h0;
            wr(8'h13, x);
            {active_line_ref, vertical_sync_pulse, field_id, horizontal_lock_status,
             fast_lock, vertical_gate_alt_position, rt_ctrl_data, crystal_clk} <= 8'($random(seed));
            {hsync_begin_field, hsync_stop_field, hsync_fine_delay} <= 18'($random(seed));
            settle;
            if (!x[6]) cmp8("hor_ref", 8'(active_line_ref), 8'(xport_hor_ref_pin));
            v = (x[4] ? field_id : vertical_sync_pulse) ^ x[5];
            cmp8("vert_ref", 8'(v), 8'(xport_vert_ref_pin));
            v = x[3] ? fast_lock : !horizontal_lock_status;
            cmp8("lock_out", 8'(v), 8'(horizontal_lock_output));
            cmp8("rtc_oe", 8'(x[7]), 8'(realtime_control_output_oe));
            cmp8("rtc_out", 8'(rt_ctrl_data), 8'(realtime_control_output));
            cmp8("xtal_out", 8'(crystal_clk), 8'(crystal_clock_output));
            v = half_rate_reference;
            @(posedge clk_sys);
            #1;
            cmp8("half_rate_reference", 8'(!v), 8'(half_rate_reference));
        end
        for (f = 0; f < 8; f++) begin
            wr(8'h13, 8'(f));
            mode <= 2'h1;
            for (i = 0; i < 6; i++) begin
                b = 8'($random(seed));
                c = 9'($random(seed));
                v = b[0];
                ex = !(f == 3 || f == 6 || (f == 2 && v));
                ev = (f == 1 && !v) ? 8'h80 : b;
                if (f >= 4) ev = (f == 4) ? c[8:1] : c[7:0];
                eh = (f == 7) ? c[8:1] : ((f == 4) ? ~c[8:1] : ~c[7:0]);
                do push(f >= 4, b, c, v); while (!ok && ex);
            end
            flush;
        end
        wr(8'h13, 8'h00);
        mode <= 2'h2;
        n = 0;
        ex = 1'b1;
        do begin
            b = 8'($random(seed));
            ev = b;
            push(1'b0, b, 9'h000, 1'b0);
            n += ok;
        end while (ok && n < 20);
        cmp8("fill depth", 8'h01, 8'(n >= 8 && n <= 10));
        flush;
        complete_run;
    end
endmodule : rxo_xport_ctrl_tb
